// ---- ddu_pkg.sv ----
// package for the dual-issue data compare debug update unit
`default_nettype none
package ddu_pkg;
  // window of retiring instructions, slot 0 is the first load/store
  localparam int DDU_NSLOT = 7;
  localparam int DDU_LDST_SLOTS = 6;
  localparam int DDU_AW = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_DEBUG_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RETURN_PC = 8'h04;
  localparam logic [7:0] ADDR_MMU_ASSIST = 8'h08;
  localparam logic [7:0] ADDR_SYNDROME = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_CONTROL = 8'h18;

  // debug_status_reg fields
  localparam int DS_FIRST_BIT = 0;
  localparam int DS_SECOND_BIT = 1;
  localparam int DS_IMPRECISE_BIT = 2;
  localparam int DS_OFST_LSB = 4;
  localparam int DS_OFST_MSB = 6;

  // exception_syndrome_reg fields
  localparam int SYN_MISS_BIT = 0;
  localparam int SYN_FAULT_BIT = 1;

  // interrupt status / mask fields
  localparam int IRQ_DEBUG_BIT = 0;
  localparam int IRQ_MISS_BIT = 1;
  localparam int IRQ_FAULT_BIT = 2;
  localparam int IRQ_MASKED_BIT = 3;
  localparam int IRQ_W = 4;

  // control fields
  localparam int CTL_ENABLE_BIT = 0;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] RESET_IRQ_MASK = 4'h0;
  localparam logic CONTROL_ENABLE_RESET = 1'b1;
  localparam logic [2:0] OFST_NONE = 3'h0;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_DEBUG = 2'b01,
    KIND_MISS = 2'b10,
    KIND_FAULT = 2'b11
  } ddu_kind_e;

  // one retiring instruction of the window
  typedef struct packed {
    logic ldst;
    logic value_qual;
    logic [1:0] hit;
    logic miss;
    logic fault;
    logic [31:0] ea;
    logic [31:0] pc;
  } ddu_slot_s;

  // decision for one window
  typedef struct packed {
    ddu_kind_e kind;
    logic [1:0] match_bits;
    logic imprecise;
    logic [2:0] ofst;
    logic [31:0] ret_pc;
    logic [5:0] count_en;
    logic masked;
  } ddu_result_s;
endpackage
`default_nettype wire

// ---- ddu_unit.sv ----
// exception choice and debug state update for dual-issued compares
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
module ddu_unit
  import ddu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic group_valid,
  input wire ddu_slot_s win [DDU_NSLOT],
  input wire logic [DDU_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic take_debug,
  output logic take_miss,
  output logic take_fault,
  output logic [5:0] count_update,
  output logic irq
);

  function automatic logic slot_fault(input ddu_slot_s s);
    return s.miss | s.fault;
  endfunction

  function automatic logic slot_hit(input ddu_slot_s s);
    return |s.hit;
  endfunction

  ddu_result_s res;
  logic [31:0] debug_status_reg;
  logic [31:0] debug_return_pc;
  logic [31:0] mmu_assist_regs;
  logic [31:0] exception_syndrome_reg;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic enable;
  logic fire;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] next_debug_status;

  assign fire = group_valid & enable;

  // decision over the window; slot 6 only lends its pc as a return point
  always_comb begin
    logic sec_found;
    logic thr_found;
    logic [2:0] sec_i;
    logic [2:0] thr_i;
    logic [2:0] last_i;
    logic [2:0] ret_i;
    ddu_slot_s s0;
    ddu_slot_s sd;
    ddu_slot_s td;
    sec_found = 1'b0;
    thr_found = 1'b0;
    sec_i = 3'h0;
    thr_i = 3'h0;
    last_i = 3'h0;
    ret_i = 3'h0;
    s0 = win[0];
    sd = win[0];
    td = win[0];
    res = '0;
    res.kind = KIND_NONE;
    res.ofst = OFST_NONE;
    for (int i = 1; i < DDU_LDST_SLOTS; i++) begin
      if (win[i].ldst) begin
        last_i = 3'(i);
        if (!sec_found) begin
          sec_found = 1'b1;
          sec_i = 3'(i);
        end else if (!thr_found) begin
          thr_found = 1'b1;
          thr_i = 3'(i);
        end
      end
    end
    if (s0.ldst) begin
      if (slot_fault(s0)) begin
        if (slot_hit(s0)) begin
          // a compare hit outranks the translation or storage fault
          res.kind = KIND_DEBUG;
          res.match_bits = s0.hit;
          res.imprecise = 1'b1;
          res.ofst = OFST_NONE;
          res.ret_pc = s0.pc;
        end else if (s0.miss) begin
          res.kind = KIND_MISS;
        end else begin
          res.kind = KIND_FAULT;
        end
      end else if (slot_hit(s0) && !s0.value_qual) begin
        res.kind = KIND_DEBUG;
        res.match_bits = s0.hit;
        res.ofst = OFST_NONE;
        res.ret_pc = win[1].pc;
        res.count_en = 6'h01;
      end else if (slot_hit(s0)) begin
        // value-qualified hit is reported late, at the next boundary
        res.kind = KIND_DEBUG;
        res.match_bits = s0.hit;
        ret_i = last_i + 3'h1;
        if (sec_found) begin
          sd = win[sec_i];
          if (slot_fault(sd)) begin
            ret_i = sec_i;
            res.masked = 1'b1;
          end else if (slot_hit(sd) && !sd.value_qual) begin
            res.match_bits = s0.hit | sd.hit;
            ret_i = sec_i + 3'h1;
          end else if (slot_hit(sd) && thr_found) begin
            // second value hit alone keeps only the first bit
            td = win[thr_i];
            if (slot_fault(td)) begin
              res.match_bits = s0.hit | sd.hit;
              ret_i = sec_i + 3'h1;
              res.masked = 1'b1;
            end else if (slot_hit(td)) begin
              res.match_bits = s0.hit | sd.hit | td.hit;
              ret_i = thr_i + 3'h1;
            end
          end
        end
        // fall through with the first bit only
        res.ret_pc = win[ret_i].pc;
        res.ofst = ret_i - 3'h1;
        for (int i = 0; i < DDU_LDST_SLOTS; i++) begin
          res.count_en[i] = (3'(i) < ret_i);
        end
      end else begin
        res.count_en = 6'h01;
      end
    end
  end

  // exception strobes and counter updates, one cycle after the group
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      take_debug <= 1'b0;
      take_miss <= 1'b0;
      take_fault <= 1'b0;
      count_update <= 6'h00;
    end else begin
      take_debug <= fire && res.kind == KIND_DEBUG;
      take_miss <= fire && res.kind == KIND_MISS;
      take_fault <= fire && res.kind == KIND_FAULT;
      count_update <= fire ? res.count_en : 6'h00;
    end
  end

  // debug status: hardware set wins over a software one-to-clear
  always_comb begin
    next_debug_status = debug_status_reg;
    if (reg_wr && reg_addr == ADDR_DEBUG_STATUS) begin
      // only the event bits clear; the offset field is read-only
      next_debug_status[DS_IMPRECISE_BIT:DS_FIRST_BIT] =
        debug_status_reg[DS_IMPRECISE_BIT:DS_FIRST_BIT] &
        ~reg_wdata[DS_IMPRECISE_BIT:DS_FIRST_BIT];
    end
    if (fire && res.kind == KIND_DEBUG) begin
      next_debug_status[DS_FIRST_BIT] = next_debug_status[DS_FIRST_BIT] |
        res.match_bits[0];
      next_debug_status[DS_SECOND_BIT] = next_debug_status[DS_SECOND_BIT] |
        res.match_bits[1];
      next_debug_status[DS_IMPRECISE_BIT] =
        next_debug_status[DS_IMPRECISE_BIT] | res.imprecise;
      next_debug_status[DS_OFST_MSB:DS_OFST_LSB] = res.ofst;
    end
    next_debug_status[31:DS_OFST_MSB+1] = '0;
    next_debug_status[DS_OFST_LSB-1] = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      debug_status_reg <= RESET_WORD;
    end else begin
      debug_status_reg <= next_debug_status;
    end
  end

  // return pointer is loaded only by a debug exception
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      debug_return_pc <= RESET_WORD;
    end else if (fire && res.kind == KIND_DEBUG) begin
      debug_return_pc <= res.ret_pc;
    end
  end

  // assist registers hold the address of the missing first ld/st
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mmu_assist_regs <= RESET_WORD;
    end else if (fire && res.kind == KIND_MISS) begin
      mmu_assist_regs <= win[0].ea;
    end
  end

  // syndrome is written by a taken miss or fault, never by debug
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      exception_syndrome_reg <= RESET_WORD;
    end else if (fire && res.kind == KIND_MISS) begin
      exception_syndrome_reg <= RESET_WORD;
      exception_syndrome_reg[SYN_MISS_BIT] <= 1'b1;
    end else if (fire && res.kind == KIND_FAULT) begin
      exception_syndrome_reg <= RESET_WORD;
      exception_syndrome_reg[SYN_FAULT_BIT] <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_SYNDROME) begin
      exception_syndrome_reg <= exception_syndrome_reg & ~reg_wdata;
    end
  end

  // interrupt events
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DEBUG_BIT] = fire && res.kind == KIND_DEBUG;
    irq_set[IRQ_MISS_BIT] = fire && res.kind == KIND_MISS;
    irq_set[IRQ_FAULT_BIT] = fire && res.kind == KIND_FAULT;
    irq_set[IRQ_MASKED_BIT] = fire && res.masked;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= '0;
    end else if (reg_wr && reg_addr == ADDR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= RESET_IRQ_MASK;
    end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end

  // disabling stops all updates from groups; groups are simply not evaluated
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable <= CONTROL_ENABLE_RESET;
    end else if (reg_wr && reg_addr == ADDR_CONTROL) begin
      enable <= reg_wdata[CTL_ENABLE_BIT];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read data stand in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= RESET_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_DEBUG_STATUS: reg_rdata <= debug_status_reg;
        ADDR_RETURN_PC: reg_rdata <= debug_return_pc;
        ADDR_MMU_ASSIST: reg_rdata <= mmu_assist_regs;
        ADDR_SYNDROME: reg_rdata <= exception_syndrome_reg;
        ADDR_IRQ_STATUS: reg_rdata <= {28'h0000000, irq_status};
        ADDR_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask};
        ADDR_CONTROL: reg_rdata <= {31'h00000000, enable};
        default: reg_rdata <= RESET_WORD;
      endcase
    end else begin
      reg_rdata <= RESET_WORD;
    end
  end

endmodule
`default_nettype wire

// ---- ddu_unit_monitor.sv ----
// assertion checker for the compare debug update unit
`default_nettype none
module ddu_unit_monitor
  import ddu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic group_valid,
  input wire ddu_slot_s win [DDU_NSLOT],
  input wire logic [DDU_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic take_debug,
  input wire logic take_miss,
  input wire logic take_fault,
  input wire logic [5:0] count_update,
  input wire logic irq
);
  // enable shadow, the checker cannot see the control register
  logic en;
  logic g;
  logic f0;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en <= CONTROL_ENABLE_RESET;
    end else if (reg_wr && reg_addr == ADDR_CONTROL) begin
      en <= reg_wdata[CTL_ENABLE_BIT];
    end
  end
  assign g = group_valid && en && win[0].ldst;
  assign f0 = win[0].miss || win[0].fault;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  property p_miss;
    g && win[0].miss && !win[0].fault && win[0].hit == 2'b00 |=> take_miss;
  endproperty
  a_miss: assert property (p_miss) else $error("miss not taken");
  property p_fault;
    g && win[0].fault && !win[0].miss && win[0].hit == 2'b00 |=> take_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not taken");
  property p_imp;
    g && f0 && win[0].hit != 2'b00 |=> take_debug && !take_miss;
  endproperty
  a_imp: assert property (p_imp) else $error("fault hit");
  property p_plain;
    g && !f0 && !win[0].value_qual && win[0].hit != 2'b00
      |=> count_update == 6'h01;
  endproperty
  a_plain: assert property (p_plain) else $error("plain hit");
  property p_qual;
    g && !f0 && win[0].value_qual && win[0].hit != 2'b00
      |=> take_debug && !take_fault;
  endproperty
  a_qual: assert property (p_qual) else $error("later fault kept");
  property p_one;
    $onehot0({take_debug, take_miss, take_fault});
  endproperty
  a_one: assert property (p_one) else $error("two exceptions");
  property p_contig;
    take_debug |-> (count_update & (count_update + 6'h01)) == 6'h00;
  endproperty
  a_contig: assert property (p_contig) else $error("gap");
  property p_noreq;
    !g |=> !take_debug && !take_miss && !take_fault;
  endproperty
  a_noreq: assert property (p_noreq) else $error("take without window");
  property p_rdata;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not idle");
  c_full: cover property (take_debug && count_update == 6'h3f);
  c_miss: cover property (take_miss);
  c_fault: cover property (take_fault);
endmodule
bind ddu_unit ddu_unit_monitor u_ddu_unit_monitor (.sys_clk(sys_clk),
  .reset_n(reset_n), .group_valid(group_valid), .win(win),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .take_debug(take_debug),
  .take_miss(take_miss), .take_fault(take_fault),
  .count_update(count_update), .irq(irq));
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the compare debug update unit
`default_nettype none
module testbench
  import ddu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SEQ_A = 7'h15;
  localparam logic [6:0] SEQ_B = 7'h25;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic group_valid = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] base = 32'h0;
  logic [31:0] kept;
  logic [31:0] reg_rdata;
  logic take_debug, take_miss, take_fault, irq;
  logic [5:0] count_update;
  ddu_slot_s win [DDU_NSLOT];
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  ddu_unit u_ddu_unit (.sys_clk(sys_clk), .reset_n(reset_n),
    .group_valid(group_valid), .win(win), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .take_debug(take_debug),
    .take_miss(take_miss), .take_fault(take_fault),
    .count_update(count_update), .irq(irq));
  always #20 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  // args: ld/st, value, miss, fault, hits, status, return slot, counts, cause
  task automatic run(input logic [6:0] ls, dv, m, f, input logic [13:0] h,
    input logic [7:0] st, input int r, input logic [5:0] c,
    input logic [1:0] sy);
    logic [2:0] k;
    k = (st[1:0] != 2'h0) ? 3'h1 : {sy, 1'b0};
    base = base + 32'h100;
    for (int i = 0; i < DDU_NSLOT; i++) begin
      win[i] <= '{ls[i], dv[i], h[2*i+:2], m[i], f[i], base + 32'(i),
        32'h100 + 32'(4 * i)};
    end
    group_valid <= 1'b1;
    @(posedge sys_clk);
    group_valid <= 1'b0;
    #1;
    chk("take", {29'h0, k}, {29'h0, take_fault, take_miss, take_debug});
    // faults and imprecise cases let no instruction complete
    chk("count", {26'h0, c}, {26'h0, count_update});
    rchk("status", ADDR_DEBUG_STATUS, {24'h0, st});
    rchk("syndrome", ADDR_SYNDROME, {30'h0, sy});
    if (r < DDU_NSLOT) begin
      rchk("return", ADDR_RETURN_PC, 32'h100 + 32'(4 * r));
    end
    wr(ADDR_DEBUG_STATUS, 32'h7);
    wr(ADDR_SYNDROME, 32'h3);
    $display("case done, status %h", st);
  endtask
  task automatic t_regs;
    rchk("status", ADDR_DEBUG_STATUS, RESET_WORD);
    rchk("control", ADDR_CONTROL, 32'h1);
    rchk("mask", ADDR_IRQ_MASK, 32'h0);
    rchk("unmapped", 8'h1c, 32'h0);
  endtask
  task automatic t_first;
    run(7'h01, 7'h00, 7'h00, 7'h01, 14'h0, 8'h00, 7, 6'h00, 2'h2);
    rchk("assist", ADDR_MMU_ASSIST, 32'h0);
    run(7'h01, 7'h00, 7'h01, 7'h00, 14'h0, 8'h00, 7, 6'h00, 2'h1);
    kept = base;
    rchk("assist", ADDR_MMU_ASSIST, kept);
  endtask
  task automatic t_imprecise;
    run(7'h01, 7'h00, 7'h01, 7'h00, 14'h1, 8'h05, 0, 6'h00, 2'h0);
    run(7'h01, 7'h00, 7'h00, 7'h01, 14'h2, 8'h06, 0, 6'h00, 2'h0);
    rchk("assist", ADDR_MMU_ASSIST, kept);
  endtask
  task automatic t_plain;
    run(7'h01, 7'h00, 7'h00, 7'h00, 14'h1, 8'h01, 1, 6'h01, 2'h0);
  endtask
  task automatic t_case_a;
    run(SEQ_A, 7'h01, 7'h00, 7'h00, 14'h1, 8'h41, 5, 6'h1f, 2'h0);
    run(SEQ_A, 7'h01, 7'h00, 7'h04, 14'h1, 8'h11, 2, 6'h03, 2'h0);
    run(SEQ_A, 7'h01, 7'h04, 7'h00, 14'h1, 8'h11, 2, 6'h03, 2'h0);
    rchk("assist", ADDR_MMU_ASSIST, kept);
    run(SEQ_A, 7'h01, 7'h00, 7'h00, 14'h21, 8'h23, 3, 6'h07, 2'h0);
    run(SEQ_A, 7'h05, 7'h00, 7'h00, 14'h21, 8'h41, 5, 6'h1f, 2'h0);
    run(SEQ_A, 7'h05, 7'h00, 7'h10, 14'h21, 8'h23, 3, 6'h07, 2'h0);
    run(SEQ_A, 7'h05, 7'h00, 7'h00, 14'h121, 8'h43, 5, 6'h1f, 2'h0);
  endtask
  task automatic t_case_b;
    run(SEQ_B, 7'h01, 7'h00, 7'h00, 14'h1, 8'h51, 6, 6'h3f, 2'h0);
    run(SEQ_B, 7'h05, 7'h00, 7'h00, 14'h21, 8'h51, 6, 6'h3f, 2'h0);
    run(SEQ_B, 7'h05, 7'h20, 7'h00, 14'h21, 8'h23, 3, 6'h07, 2'h0);
    run(SEQ_B, 7'h05, 7'h00, 7'h00, 14'h421, 8'h53, 6, 6'h3f, 2'h0);
    wr(ADDR_DEBUG_STATUS, 32'hff);
    rchk("offset kept", ADDR_DEBUG_STATUS, 32'h50);
  endtask
  task automatic t_irq;
    rchk("irq status", ADDR_IRQ_STATUS, 32'hf);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'hf);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_CONTROL, 32'h0);
    run(7'h01, 7'h00, 7'h00, 7'h00, 14'h1, 8'h50, 7, 6'h00, 2'h0);
    rchk("irq status off", ADDR_IRQ_STATUS, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(ADDR_CONTROL, 32'h1);
  endtask
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a hung handshake must still reach the closing report
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    for (int i = 0; i < DDU_NSLOT; i++) begin
      win[i] = '0;
    end
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_first();
    t_imprecise();
    t_plain();
    t_case_a();
    t_case_b();
    t_irq();
    end_sim();
  end
endmodule
`default_nettype wire
